// >>> core/pieb_bank.sv
/*
 * Peripheral interrupt enable bank: two enable registers that mask the
 * peripheral event sources toward the core's interrupt logic, a control
 * register for priority mode and the global peripheral enable, and a small
 * event status/mask pair that drives one interrupt output.
 * Assumes source lines come from other logic or pins and are synchronised
 * here; the register port follows a one-cycle strobe protocol.
 */
`timescale 1ns/1ps
module pieb_bank #(
   parameter bit LARGE_PACKAGE = 1'b1
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Register port.
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Peripheral event sources, first and second group, register layout.
   input wire logic [7:0] src_group_a_i,
   input wire logic [7:0] src_group_b_i,
   // High-priority selections per source, from the priority registers.
   input wire logic [7:0] prio_group_a_i,
   input wire logic [7:0] prio_group_b_i,
   // High while the device runs from internal program memory.
   input wire logic microcontroller_mode_i,
   // Delivered peripheral requests toward the core.
   output logic [7:0] irq_group_a_o,
   output logic [7:0] irq_group_b_o,
   output logic irq_high_o,
   output logic irq_low_o,
   // Summary interrupt from the event status register.
   output logic irq_o
);

   // ****************************************************************
   // Input capture.
   // ****************************************************************

   // Bundled register request, same clock, so no synchroniser.
   // One assignment drives the whole bundle, so it has a single driver.
   pieb_pkg::pieb_bus_req_type req;
   assign req = '{
      addr: reg_addr_i,
      wdata: reg_wdata_i,
      wr: reg_wr_i,
      rd: reg_rd_i
   };

   // Sources, priorities and mode may come from pins; all pass two flops.
   pieb_pkg::pieb_src_type src_raw;
   pieb_pkg::pieb_src_type src;
   pieb_pkg::pieb_src_type prio;
   logic [7:0] src_a_sync;
   logic [7:0] src_b_sync;
   logic [7:0] prio_a_sync;
   logic [7:0] prio_b_sync;
   logic mc_mode_sync;
   // Raw source levels in register layout, before the flops.
   assign src_raw = '{
      group_a: src_group_a_i,
      group_b: src_group_b_i
   };

   // One synchroniser handles every asynchronous level.
   pieb_sync #(
      .WIDTH(33)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .async_i({src_raw, prio_group_a_i, prio_group_b_i, microcontroller_mode_i}),
      .sync_o({src_a_sync, src_b_sync, prio_a_sync, prio_b_sync, mc_mode_sync})
   );
   // Synchronised sources, regrouped by row.
   assign src = '{
      group_a: src_a_sync,
      group_b: src_b_sync
   };
   // Priority bits are only read in priority mode; they still pass two
   // flops so a changing pin never feeds a metastable value to the routing.
   assign prio = '{
      group_a: prio_a_sync,
      group_b: prio_b_sync
   };

   // ****************************************************************
   // Register state.
   // ****************************************************************

   // First enable register.
   logic [7:0] enable_a_q;
   // Second enable register, unimplemented bits held at zero.
   logic [7:0] enable_b_q;
   // Control: priority mode and peripheral global enable.
   logic [7:0] control_q;
   // Sticky event status and its mask.
   logic [7:0] status_q;
   logic [7:0] mask_q;
   // Read data, valid the cycle after the strobe.
   logic [7:0] rdata_q;

   // Decoded write strobes.
   // Each is a plain compare of the word address; the port never waits.
   logic wr_enable_a;
   logic wr_enable_b;
   logic wr_control;
   logic wr_status;
   logic wr_mask;
   assign wr_enable_a = req.wr && (req.addr == pieb_pkg::PIEB_OFF_ENABLE_A);
   assign wr_enable_b = req.wr && (req.addr == pieb_pkg::PIEB_OFF_ENABLE_B);
   assign wr_control = req.wr && (req.addr == pieb_pkg::PIEB_OFF_CONTROL);
   assign wr_status = req.wr && (req.addr == pieb_pkg::PIEB_OFF_STATUS);
   assign wr_mask = req.wr && (req.addr == pieb_pkg::PIEB_OFF_MASK);

   // Any write to an address that holds no writable register, including the read-only live readback.
   logic wr_unmapped;
   assign wr_unmapped = req.wr && !(wr_enable_a || wr_enable_b || wr_control ||
      wr_status || wr_mask);

   // first register
   // Every bit of the first enable register is plain read/write storage.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         enable_a_q <= pieb_pkg::PIEB_RST_ENABLE_A;
      end else if (wr_enable_a) begin
         enable_a_q <= req.wdata;
      end
   end

   // second register
   // The second register only keeps its implemented bits.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         enable_b_q <= pieb_pkg::PIEB_RST_ENABLE_B;
      end else if (wr_enable_b) begin
         enable_b_q <= req.wdata & pieb_pkg::PIEB_IMPL_ENABLE_B;
      end
   end

   // Control register keeps only its two defined bits.
   // Bit 0 selects priority mode, bit 1 is the peripheral global enable.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         control_q <= pieb_pkg::PIEB_RST_CONTROL;
      end else if (wr_control) begin
         control_q <= req.wdata & 8'h03;
      end
   end

   // Mask register for the event status.
   // Only the two event bits exist; the upper bits always read zero.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         mask_q <= pieb_pkg::PIEB_RST_MASK;
      end else if (wr_mask) begin
         mask_q <= req.wdata & 8'h03;
      end
   end

   // Named views of the two control bits used by the gating below.
   logic priority_mode_enable;
   logic peripheral_global_enable;
   assign priority_mode_enable = control_q[pieb_pkg::PIEB_BIT_PRIORITY_MODE];
   assign peripheral_global_enable = control_q[pieb_pkg::PIEB_BIT_PERIPH_GLOBAL];

   // ****************************************************************
   // Gating.
   // ****************************************************************

   // global enable gate
   // In priority mode the rows are always permitted; the core's own
   // high/low enables then decide, which sit outside this bank.
   logic row_permit;
   assign row_permit = priority_mode_enable || peripheral_global_enable;

   // microcontroller mode only
   // On small packages the parallel slave port enable behaves normally.
   logic [7:0] enable_a_eff;
   always_comb begin
      enable_a_eff = enable_a_q;
      if (LARGE_PACKAGE && !mc_mode_sync) begin
         enable_a_eff[pieb_pkg::PIEB_BIT_PARALLEL_SLAVE] = 1'b0;
      end
   end

   // Gated requests of each row, before the output flops.
   logic [7:0] pass_a;
   logic [7:0] pass_b;

   // First row: the eight sources of the first register.
   pieb_gate #(
      .WIDTH(8)
   ) u_gate_a (
      .req_i(src.group_a),
      .enable_i(enable_a_eff),
      .permit_i(row_permit),
      .pass_o(pass_a)
   );

   // second row gate
   // Second row; bits 7 and 5 never pass since their enables stay zero.
   pieb_gate #(
      .WIDTH(8)
   ) u_gate_b (
      .req_i(src.group_b),
      .enable_i(enable_b_q),
      .permit_i(row_permit),
      .pass_o(pass_b)
   );

   // priority routing
   // Without priority mode everything goes to the high vector, so the
   // priority inputs are ignored entirely.
   logic any_high;
   logic any_low;
   assign any_high = priority_mode_enable ?
      (|(pass_a & prio.group_a) || |(pass_b & prio.group_b)) :
      (|pass_a || |pass_b);
   assign any_low = priority_mode_enable &&
      (|(pass_a & ~prio.group_a) || |(pass_b & ~prio.group_b));

   // ****************************************************************
   // Outputs to the core.
   // ****************************************************************

   // Registered so every output leaves a flip-flop; costs one cycle.
   // A source change shows three cycles late: two synchroniser flops
   // and this output flop.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         irq_group_a_o <= 8'h00;
         irq_group_b_o <= 8'h00;
         irq_high_o <= 1'b0;
         irq_low_o <= 1'b0;
      end else begin
         irq_group_a_o <= pass_a;
         irq_group_b_o <= pass_b;
         irq_high_o <= any_high;
         irq_low_o <= any_low;
      end
   end

   // ****************************************************************
   // Event status and interrupt.
   // ****************************************************************

   // Rising edge of delivery, from a registered copy.
   // Only the first cycle counts, so a request that stays asserted does
   // not set the status bit again right after software clears it.
   logic deliver_q;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         deliver_q <= 1'b0;
      end else begin
         deliver_q <= any_high || any_low;
      end
   end

   // Event bits that hardware sets this cycle; all others stay clear.
   logic [7:0] evt_set;
   always_comb begin
      evt_set = 8'h00;
      evt_set[pieb_pkg::PIEB_BIT_EVT_DELIVER] = (any_high || any_low) && !deliver_q;
      evt_set[pieb_pkg::PIEB_BIT_EVT_WRITE_IGNORED] = wr_unmapped;
   end

   // Write one to clear; a set in the same cycle wins over the clear.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         status_q <= pieb_pkg::PIEB_RST_STATUS;
      end else begin
         status_q <= (status_q & ~(wr_status ? req.wdata : 8'h00)) | evt_set;
      end
   end

   // Level interrupt while any unmasked status bit is set.
   // The next status value is used so the output follows a set or a
   // clear in the same cycle as the status register itself.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(((status_q & ~(wr_status ? req.wdata : 8'h00)) | evt_set) & mask_q);
      end
   end

   // ****************************************************************
   // Read port.
   // ****************************************************************

   // Unmapped reads return zero; data stands only in the following cycle.
   // The live readback shows row summaries, mode and routing, so software
   // can see why a request is or is not delivered.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         rdata_q <= 8'h00;
      end else if (req.rd) begin
         case (req.addr)
            pieb_pkg::PIEB_OFF_ENABLE_A: begin
               rdata_q <= enable_a_q;
            end
            pieb_pkg::PIEB_OFF_ENABLE_B: begin
               rdata_q <= enable_b_q;
            end
            pieb_pkg::PIEB_OFF_CONTROL: begin
               rdata_q <= control_q;
            end
            pieb_pkg::PIEB_OFF_STATUS: begin
               rdata_q <= status_q;
            end
            pieb_pkg::PIEB_OFF_MASK: begin
               rdata_q <= mask_q;
            end
            pieb_pkg::PIEB_OFF_SOURCES: begin
               rdata_q <= {pass_a[7:4] != 4'h0, pass_a[3:0] != 4'h0,
                  pass_b[7:4] != 4'h0, pass_b[3:0] != 4'h0,
                  mc_mode_sync, row_permit, any_low, any_high};
            end
            default: begin
               rdata_q <= 8'h00;
            end
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata_o = rdata_q;

endmodule : pieb_bank

// >>> core/pieb_gate.sv
/*
 * One row of interrupt gates: each request passes only while its enable
 * bit is set and the row is permitted.
 * Assumes requests and enables are on the system clock already.
 */
`timescale 1ns/1ps
module pieb_gate #(
   parameter int WIDTH = 8
) (
   input wire logic [WIDTH-1:0] req_i,
   input wire logic [WIDTH-1:0] enable_i,
   input wire logic permit_i,
   output logic [WIDTH-1:0] pass_o
);

   // ****************************************************************
   // Per-bit gating.
   // ****************************************************************

   // Each bit is an independent AND of request, enable and permit.
   genvar g;
   for (g = 0; g < WIDTH; g++) begin : g_bit
      assign pass_o[g] = req_i[g] & enable_i[g] & permit_i;
   end

endmodule : pieb_gate

// >>> core/pieb_pkg.sv
/*
 * Package for the peripheral interrupt enable bank: register offsets, field
 * positions, reset values and the carrier structs shared by the design files.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
package pieb_pkg;

   // ****************************************************************
   // Register map.
   // ****************************************************************

   // Word offsets of the registers on the plain register port.
   localparam logic [3:0] PIEB_OFF_ENABLE_A = 4'h0;
   localparam logic [3:0] PIEB_OFF_ENABLE_B = 4'h1;
   localparam logic [3:0] PIEB_OFF_CONTROL = 4'h2;
   localparam logic [3:0] PIEB_OFF_STATUS = 4'h3;
   localparam logic [3:0] PIEB_OFF_MASK = 4'h4;
   localparam logic [3:0] PIEB_OFF_SOURCES = 4'h5;

   // Values after reset.
   localparam logic [7:0] PIEB_RST_ENABLE_A = 8'h00;
   localparam logic [7:0] PIEB_RST_ENABLE_B = 8'h00;
   localparam logic [7:0] PIEB_RST_CONTROL = 8'h00;
   localparam logic [7:0] PIEB_RST_STATUS = 8'h00;
   localparam logic [7:0] PIEB_RST_MASK = 8'h00;

   // Writable bits of the second enable register; bits 7 and 5 do not exist.
   localparam logic [7:0] PIEB_IMPL_ENABLE_B = 8'h5f;

   // ****************************************************************
   // Field positions.
   // ****************************************************************

   // First enable register.
   localparam int PIEB_BIT_PARALLEL_SLAVE = 7;
   localparam int PIEB_BIT_ANALOG_CONV = 6;
   localparam int PIEB_BIT_UART1_RECEIVE = 5;
   localparam int PIEB_BIT_UART1_TRANSMIT = 4;
   localparam int PIEB_BIT_SYNC_SERIAL = 3;
   localparam int PIEB_BIT_CAPCMP1 = 2;
   localparam int PIEB_BIT_TIMER2_MATCH = 1;
   localparam int PIEB_BIT_TIMER1_OVERFLOW = 0;
   // Second enable register.
   localparam int PIEB_BIT_COMPARATOR = 6;
   localparam int PIEB_BIT_NVM_WRITE = 4;
   localparam int PIEB_BIT_BUS_COLLISION = 3;
   localparam int PIEB_BIT_LOW_VOLTAGE = 2;
   localparam int PIEB_BIT_TIMER3_OVERFLOW = 1;
   localparam int PIEB_BIT_CAPCMP2 = 0;
   // Control register.
   localparam int PIEB_BIT_PRIORITY_MODE = 0;
   localparam int PIEB_BIT_PERIPH_GLOBAL = 1;
   // Status and mask registers.
   localparam int PIEB_BIT_EVT_DELIVER = 0;
   localparam int PIEB_BIT_EVT_WRITE_IGNORED = 1;

   // ****************************************************************
   // Carrier types.
   // ****************************************************************

   // One register access from the master.
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } pieb_bus_req_type;

   // The sixteen source lines, two rows of eight, in register layout.
   typedef struct packed {
      logic [7:0] group_a;
      logic [7:0] group_b;
   } pieb_src_type;

endpackage : pieb_pkg

// >>> core/pieb_sync.sv
/*
 * Two-flip-flop synchroniser for a group of level inputs.
 * Assumes each bit is a slow level; words are not kept coherent.
 */
`timescale 1ns/1ps
module pieb_sync #(
   parameter int WIDTH = 16
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   // ****************************************************************
   // Synchroniser stages.
   // ****************************************************************

   // First stage; only the second stage reads it.
   logic [WIDTH-1:0] meta_q;
   // Second stage, safe to use.
   logic [WIDTH-1:0] stable_q;

   // Both stages clear on reset to a constant.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         meta_q <= '0;
         stable_q <= '0;
      end else begin
         meta_q <= async_i;
         stable_q <= meta_q;
      end
   end

   assign sync_o = stable_q;

endmodule : pieb_sync

// >>> tb/pieb_bank_assertions.sv
/*
 * Port-level checker for the peripheral interrupt enable bank.
 * Assumes it is bound to pieb_bank and that reset is held for two edges or more.
 */
`timescale 1ns/1ps
module pieb_bank_assertions (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [7:0] src_group_a_i,
   input wire logic [7:0] src_group_b_i,
   input wire logic microcontroller_mode_i,
   input wire logic [7:0] irq_group_a_o,
   input wire logic [7:0] irq_group_b_o,
   input wire logic irq_high_o,
   input wire logic irq_low_o,
   input wire logic irq_o
);
   // ****************************************************************
   // Shadow state.
   // ****************************************************************
   // Copies of the registers, rebuilt from the writes seen on the port.
   logic [7:0] en_a_q, en_b_q;
   logic [1:0] ctl_q, mask_q;
   // Two-stage delay that matches the source synchroniser.
   logic [7:0] s1a_q, s2a_q, s1b_q, s2b_q;
   // A row is permitted in priority mode or with the global enable.
   wire logic permit = |ctl_q;

   // Register shadows follow every write; reserved bits are dropped.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         en_a_q <= 8'h00;
         en_b_q <= 8'h00;
         ctl_q <= 2'b00;
         mask_q <= 2'b00;
      end else if (reg_wr_i) begin
         if (reg_addr_i == pieb_pkg::PIEB_OFF_ENABLE_A) en_a_q <= reg_wdata_i;
         if (reg_addr_i == pieb_pkg::PIEB_OFF_ENABLE_B) en_b_q <= reg_wdata_i & 8'h5f;
         if (reg_addr_i == pieb_pkg::PIEB_OFF_CONTROL) ctl_q <= reg_wdata_i[1:0];
         if (reg_addr_i == pieb_pkg::PIEB_OFF_MASK) mask_q <= reg_wdata_i[1:0];
      end
   end

   // Source delay line, cleared by reset like the design's own flops.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_b_i) begin
         {s1a_q, s2a_q, s1b_q, s2b_q} <= 32'h0000_0000;
      end else begin
         {s1a_q, s2a_q, s1b_q, s2b_q} <= {src_group_a_i, s1a_q, src_group_b_i, s1b_q};
      end
   end

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);

   a_row_a_gate: assert property (
      $past(rst_b_i) |-> irq_group_a_o[6:0] ==
         ($past(s2a_q[6:0]) & $past(en_a_q[6:0]) & {7{$past(permit)}}))
      else $error("first row output differs from its gated sources");
   a_row_b_gate: assert property (
      $past(rst_b_i) |-> irq_group_b_o ==
         ($past(s2b_q) & $past(en_b_q) & {8{$past(permit)}}))
      else $error("second row output differs from its gated sources");
   a_global_off: assert property (
      !ctl_q[0] && !ctl_q[1] |=> irq_group_a_o == 8'h00 && irq_group_b_o == 8'h00 && !irq_high_o)
      else $error("request delivered with global enable off");
   a_psp_mode: assert property (
      !microcontroller_mode_i [*5] |-> !irq_group_a_o[7])
      else $error("parallel slave request outside microcontroller mode");
   a_flat_no_low: assert property (
      !ctl_q[0] [*2] |-> !irq_low_o)
      else $error("low priority output outside priority mode");
   a_flat_high_any: assert property (
      $past(rst_b_i) && !$past(ctl_q[0]) |-> irq_high_o == (|{irq_group_a_o, irq_group_b_o}))
      else $error("high output not the sum of requests outside priority mode");
   a_ena_read: assert property (
      $past(reg_rd_i) && $past(reg_addr_i) == pieb_pkg::PIEB_OFF_ENABLE_A |->
         reg_rdata_o == $past(en_a_q))
      else $error("first enable register reads back wrong");
   a_enb_read: assert property (
      $past(reg_rd_i) && $past(reg_addr_i) == pieb_pkg::PIEB_OFF_ENABLE_B |->
         reg_rdata_o == $past(en_b_q))
      else $error("second enable register reads back wrong");
   a_irq_masked: assert property (
      irq_o |-> $past(mask_q) != 2'b00)
      else $error("summary interrupt raised with all events masked");
endmodule : pieb_bank_assertions

// >>> tb/pieb_bank_test.sv
/*
 * Self-checking bench for the enable bank: register access, gating in every
 * control mode with random sources, and the summary interrupt.
 * Assumes the design package and modules are compiled first.
 */
`timescale 1ns/1ps
module pieb_bank_test;
   // ****************************************************************
   // Stimulus and observation signals.
   // ****************************************************************
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   pieb_pkg::pieb_bus_req_type req_q = '0;
   logic [7:0] want_a = 8'h00, want_b = 8'h00, prio_a = 8'h00, prio_b = 8'h00;
   logic mc_q = 1'b1;
   logic chk_q = 1'b0;
   logic rd_p = 1'b0;
   pieb_pkg::pieb_src_type src;
   logic [7:0] reg_rdata_o, irq_a, irq_b;
   logic irq_high, irq_low, irq;
   // Expected read data and expected output snapshots, oldest first.
   logic [31:0] exp_rd[$];
   logic [31:0] exp_irq[$];
   integer seed = 32'h0000_0597;
   int n_fail = 0;
   int tests_run = 0;

   pieb_src_model u_src (.clk_sys_i(clk_sys_i), .want_a_i(want_a), .want_b_i(want_b),
      .src_o(src));
   pieb_bank dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reg_addr_i(req_q.addr),
      .reg_wdata_i(req_q.wdata), .reg_wr_i(req_q.wr), .reg_rd_i(req_q.rd),
      .reg_rdata_o(reg_rdata_o), .src_group_a_i(src.group_a), .src_group_b_i(src.group_b),
      .prio_group_a_i(prio_a), .prio_group_b_i(prio_b), .microcontroller_mode_i(mc_q),
      .irq_group_a_o(irq_a), .irq_group_b_o(irq_b), .irq_high_o(irq_high),
      .irq_low_o(irq_low), .irq_o(irq));

   // 250 MHz system clock.
   initial begin
      forever #2 clk_sys_i = ~clk_sys_i;
   end

   // ****************************************************************
   // Tasks.
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      tests_run++;
      if (seen !== want) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check

   task automatic conclude();
      if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude

   // Strobes last one cycle; back-to-back calls need no idle gap.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      req_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_i);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      req_q <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      exp_rd.push_back(32'(e));
      @(posedge clk_sys_i);
   endtask : rd

   task automatic idle(input int n);
      req_q <= '0;
      repeat (n) @(posedge clk_sys_i);
   endtask : idle

   task automatic irq_chk(input logic [18:0] e);
      exp_irq.push_back(32'(e));
      chk_q <= 1'b1;
      @(posedge clk_sys_i);
      chk_q <= 1'b0;
   endtask : irq_chk

   // One gating case: random enables, sources and priorities under one mode.
   task automatic gate_case(input logic [1:0] ctl);
      logic [7:0] sa, sb, ea, eb, pa, pb, ga, gb;
      logic mc, hi, lo;
      {sa, sb, ea, eb} = 32'($random(seed));
      {pa, pb} = 16'($random(seed));
      mc = 1'($random(seed));
      wr(pieb_pkg::PIEB_OFF_CONTROL, {6'h00, ctl});
      wr(pieb_pkg::PIEB_OFF_ENABLE_A, ea);
      wr(pieb_pkg::PIEB_OFF_ENABLE_B, eb);
      want_a <= sa;
      want_b <= sb;
      prio_a <= pa;
      prio_b <= pb;
      mc_q <= mc;
      idle(8);
      ga = sa & ea & {8{|ctl}};
      ga[7] = ga[7] & mc;
      gb = sb & eb & pieb_pkg::PIEB_IMPL_ENABLE_B & {8{|ctl}};
      hi = ctl[0] ? |((ga & pa) | (gb & pb)) : |{ga, gb};
      lo = ctl[0] & |((ga & ~pa) | (gb & ~pb));
      irq_chk({ga, gb, hi, lo, 1'b0});
   endtask : gate_case

   // ****************************************************************
   // Result monitor: each result takes the oldest matching note.
   // ****************************************************************
   always @(posedge clk_sys_i) begin
      if (rd_p) check(32'(reg_rdata_o), exp_rd.pop_front());
      if (chk_q) check(32'({irq_a, irq_b, irq_high, irq_low, irq}), exp_irq.pop_front());
      rd_p <= req_q.rd;
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      #20000;
      n_fail++;
      conclude();
   end

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      repeat (12) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      @(posedge clk_sys_i);
      for (int i = 0; i < 5; i++) rd(4'(i), 8'h00);
      wr(pieb_pkg::PIEB_OFF_ENABLE_B, 8'hff);
      rd(pieb_pkg::PIEB_OFF_ENABLE_B, pieb_pkg::PIEB_IMPL_ENABLE_B);
      wr(pieb_pkg::PIEB_OFF_ENABLE_A, 8'hff);
      rd(pieb_pkg::PIEB_OFF_ENABLE_A, 8'hff);
      wr(pieb_pkg::PIEB_OFF_CONTROL, 8'hff);
      rd(pieb_pkg::PIEB_OFF_CONTROL, 8'h03);
      // Unmapped places read zero and a stray write is flagged, then cleared.
      rd(4'hf, 8'h00);
      wr(4'he, 8'h55);
      rd(pieb_pkg::PIEB_OFF_STATUS, 8'h02);
      wr(pieb_pkg::PIEB_OFF_STATUS, 8'h02);
      rd(pieb_pkg::PIEB_OFF_STATUS, 8'h00);
      for (int c = 0; c < 4; c++) begin
         repeat (6) gate_case(2'(c));
      end
      // Interrupt: raise on delivery, mask, unmask, then clear.
      want_a <= 8'h00;
      want_b <= 8'h00;
      mc_q <= 1'b1;
      idle(8);
      wr(pieb_pkg::PIEB_OFF_STATUS, 8'h03);
      wr(pieb_pkg::PIEB_OFF_CONTROL, 8'h02);
      wr(pieb_pkg::PIEB_OFF_ENABLE_A, 8'h01);
      wr(pieb_pkg::PIEB_OFF_MASK, 8'h01);
      want_a <= 8'h01;
      idle(8);
      irq_chk({8'h01, 8'h00, 3'b101});
      rd(pieb_pkg::PIEB_OFF_STATUS, 8'h01);
      // Live readback: low nibble of row a, mode, permit and high vector.
      rd(pieb_pkg::PIEB_OFF_SOURCES, 8'h4d);
      wr(pieb_pkg::PIEB_OFF_MASK, 8'h00);
      idle(4);
      irq_chk({8'h01, 8'h00, 3'b100});
      wr(pieb_pkg::PIEB_OFF_MASK, 8'h01);
      idle(4);
      irq_chk({8'h01, 8'h00, 3'b101});
      wr(pieb_pkg::PIEB_OFF_STATUS, 8'h01);
      idle(4);
      irq_chk({8'h01, 8'h00, 3'b100});
      idle(4);
      conclude();
   end
endmodule : pieb_bank_test

bind pieb_bank pieb_bank_assertions u_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .src_group_a_i(src_group_a_i),
   .src_group_b_i(src_group_b_i), .microcontroller_mode_i(microcontroller_mode_i),
   .irq_group_a_o(irq_group_a_o), .irq_group_b_o(irq_group_b_o),
   .irq_high_o(irq_high_o), .irq_low_o(irq_low_o), .irq_o(irq_o));

// >>> tb/pieb_src_model.sv
/*
 * Model of the peripheral event sources: holds each commanded level from the
 * next clock edge on. Assumes the bench commands levels on the system clock.
 */
`timescale 1ns/1ps
module pieb_src_model (
   input wire logic clk_sys_i,
   input wire logic [7:0] want_a_i,
   input wire logic [7:0] want_b_i,
   output pieb_pkg::pieb_src_type src_o
);
   // Levels start low so the design never sees an unknown source.
   pieb_pkg::pieb_src_type src_q = '0;
   assign src_o = src_q;

   // Only real sources exist in the second row; the two empty places stay low.
   always @(posedge clk_sys_i) begin
      src_q.group_a <= want_a_i;
      src_q.group_b <= want_b_i & pieb_pkg::PIEB_IMPL_ENABLE_B;
   end
endmodule : pieb_src_model
